// ### design/sptd_core.v
// spi transfer engine: master or slave, four clock modes, double-buffered tx and rx, dma handshakes
// assumes all inputs synchronous to ref_clk; serial pins other than slave_select_n are split into in, out and enable
`timescale 1ns/1ps
`include "sptd_map.vh"

module sptd_core (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// configuration
	input wire enable,
	input wire master_mode,
	input wire clock_polarity,
	input wire clock_phase,
	input wire bit_order_select,
	input wire [15:0] baud_divisor,
	input wire rx_dma_irq_enable,
	input wire tx_dma_irq_enable,
	// software data access
	input wire tx_write,
	input wire [7:0] tx_wdata,
	input wire rx_read,
	output reg [7:0] rx_rdata,
	output reg tx_ready,
	output reg rx_ready,
	output reg busy,
	// status
	input wire status_clear,
	output reg rx_dma_done_flag,
	output reg tx_dma_done_flag,
	output reg dma_irq,
	// dma handshake
	input wire rx_dma_enable,
	input wire tx_dma_enable,
	output reg rx_dma_req,
	input wire rx_dma_ack,
	output reg tx_dma_req,
	input wire tx_dma_ack,
	input wire rx_dma_done,
	input wire tx_dma_done,
	// serial pins
	input wire sclk_in,
	output reg sclk_out,
	output reg sclk_oe,
	input wire slave_select_n,
	input wire mosi_in,
	output reg mosi_out,
	output reg mosi_oe,
	input wire miso_in,
	output reg miso_out,
	output reg miso_oe
);

localparam ST_IDLE = 2'd0;
localparam ST_LEAD = 2'd1;
localparam ST_TRAIL = 2'd2;

// ********************************************
// shared state
// ********************************************
reg [1:0] state;
reg [15:0] div_cnt;
reg [3:0] bit_cnt;
reg [7:0] tx_data_holding;
reg tx_full;
reg [7:0] shift_tx;
reg [7:0] shift_rx;
reg sclk_prev;
reg ss_prev;
reg sel_active;
reg dummy_pending;
reg rx_dma_done_prev;
reg tx_dma_done_prev;
reg tx_req_armed;
reg rx_req_armed;
reg out_bit;

wire [15:0] baud_eff = (baud_divisor < `SPTD_BAUD_MIN) ? `SPTD_BAUD_MIN : baud_divisor;
wire half_tick = (div_cnt >= (baud_eff >> 1));
wire [7:0] load_src = (dummy_pending && tx_dma_enable) ? `SPTD_DUMMY_BYTE : tx_data_holding;
wire first_bit = bit_order_select ? shift_tx[7] : shift_tx[0];
wire sample_bit = master_mode ? miso_in : mosi_in;

// slave edges seen on sclk_in; leading is idle-to-active whatever the polarity
wire s_clk_lvl = sclk_in ^ clock_polarity;
wire s_prev_lvl = sclk_prev ^ clock_polarity;
wire s_lead = s_clk_lvl && !s_prev_lvl;
wire s_trail = !s_clk_lvl && s_prev_lvl;
wire ss_fall = ss_prev && !slave_select_n;

function [7:0] push_in;
	input [7:0] cur;
	input msb_first;
	input b;
	begin
		push_in = msb_first ? {cur[6:0], b} : {b, cur[7:1]};
	end
endfunction

function [7:0] pop_out;
	input [7:0] cur;
	input msb_first;
	begin
		pop_out = msb_first ? {cur[6:0], 1'b0} : {1'b0, cur[7:1]};
	end
endfunction

function pick;
	input [7:0] v;
	input msb_first;
	begin
		pick = msb_first ? v[7] : v[0];
	end
endfunction

// ********************************************
// transfer engine
// ********************************************
always @(posedge ref_clk) begin
	if (!rstn) begin
		state <= ST_IDLE;
		div_cnt <= 16'h0000;
		bit_cnt <= 4'h0;
		tx_data_holding <= 8'h00;
		tx_full <= 1'b0;
		shift_tx <= 8'h00;
		shift_rx <= 8'h00;
		rx_rdata <= 8'h00;
		rx_ready <= 1'b0;
		tx_ready <= 1'b1;
		busy <= 1'b0;
		sclk_out <= 1'b0;
		sclk_oe <= 1'b0;
		mosi_out <= 1'b0;
		mosi_oe <= 1'b0;
		miso_out <= 1'b0;
		miso_oe <= 1'b0;
		sclk_prev <= 1'b0;
		ss_prev <= 1'b1;
		sel_active <= 1'b0;
		dummy_pending <= 1'b1;
		out_bit <= 1'b0;
	end else begin
		sclk_prev <= sclk_in;
		ss_prev <= slave_select_n;
		// polarity only flips the driven clock level
		sclk_out <= ((state == ST_TRAIL) ^ clock_polarity);
		sclk_oe <= enable && master_mode;
		// master select pin is an input here and must be held high externally
		mosi_oe <= enable && master_mode;
		miso_oe <= enable && !master_mode && sel_active;
		mosi_out <= out_bit;
		miso_out <= out_bit;
		tx_ready <= !tx_full;
		busy <= (state != ST_IDLE) || sel_active;
		if (tx_write) begin
			tx_data_holding <= tx_wdata;
			tx_full <= 1'b1;
		end
		if (rx_read) begin
			rx_ready <= 1'b0;
		end
		if (!enable) begin
			state <= ST_IDLE;
			sel_active <= 1'b0;
			div_cnt <= 16'h0000;
		end else if (master_mode) begin
			sel_active <= 1'b0;
			case (state)
				ST_IDLE: begin
					// a full holding register launches the next byte after a single idle cycle
					if (tx_full) begin
						shift_tx <= tx_data_holding;
						tx_full <= tx_write;
						bit_cnt <= 4'h0;
						div_cnt <= 16'h0000;
						// phase zero drives the first bit now and waits half a period
						out_bit <= pick(tx_data_holding, bit_order_select);
						state <= clock_phase ? ST_TRAIL : ST_LEAD;
					end
				end
				ST_LEAD: begin
					div_cnt <= div_cnt + 16'h0001;
					if (half_tick) begin
						div_cnt <= 16'h0000;
						state <= ST_TRAIL;
						if (!clock_phase) begin
							shift_rx <= push_in(shift_rx, bit_order_select, sample_bit);
						end else begin
							shift_tx <= pop_out(shift_tx, bit_order_select);
							out_bit <= pick(pop_out(shift_tx, bit_order_select), bit_order_select);
						end
					end
				end
				default: begin
					if (clock_phase && bit_cnt == 4'h0 && div_cnt == 16'h0000) begin
						out_bit <= first_bit;
					end
					div_cnt <= div_cnt + 16'h0001;
					if (half_tick) begin
						div_cnt <= 16'h0000;
						bit_cnt <= bit_cnt + 4'h1;
						if (clock_phase) begin
							shift_rx <= push_in(shift_rx, bit_order_select, sample_bit);
						end else begin
							shift_tx <= pop_out(shift_tx, bit_order_select);
							out_bit <= pick(pop_out(shift_tx, bit_order_select), bit_order_select);
						end
						if (bit_cnt == `SPTD_BITS - 4'h1) begin
							state <= ST_IDLE;
							rx_rdata <= clock_phase ? push_in(shift_rx, bit_order_select, sample_bit) : shift_rx;
							rx_ready <= 1'b1;
						end else begin
							state <= ST_LEAD;
							if (clock_phase) begin
								out_bit <= pick(shift_tx, bit_order_select);
							end
						end
					end
				end
			endcase
		end else begin
			state <= ST_IDLE;
			if (slave_select_n) begin
				sel_active <= 1'b0;
			end else if (ss_fall) begin
				sel_active <= 1'b1;
				bit_cnt <= 4'h0;
				shift_tx <= load_src;
				dummy_pending <= 1'b0;
				if (!(dummy_pending && tx_dma_enable)) begin
					tx_full <= tx_write;
				end
				if (!clock_phase) begin
					out_bit <= pick(load_src, bit_order_select);
				end
				// phase one leaves out_bit at its previous value until the first leading edge
			end else if (sel_active) begin
				if (s_lead) begin
					if (clock_phase) begin
						out_bit <= pick(shift_tx, bit_order_select);
						shift_tx <= pop_out(shift_tx, bit_order_select);
					end else begin
						shift_rx <= push_in(shift_rx, bit_order_select, mosi_in);
					end
				end
				if (s_trail) begin
					bit_cnt <= bit_cnt + 4'h1;
					if (clock_phase) begin
						shift_rx <= push_in(shift_rx, bit_order_select, mosi_in);
					end else begin
						shift_tx <= pop_out(shift_tx, bit_order_select);
						out_bit <= pick(pop_out(shift_tx, bit_order_select), bit_order_select);
					end
					if (bit_cnt == `SPTD_BITS - 4'h1) begin
						bit_cnt <= 4'h0;
						rx_rdata <= clock_phase ? push_in(shift_rx, bit_order_select, mosi_in) : shift_rx;
						rx_ready <= 1'b1;
						shift_tx <= tx_data_holding;
						tx_full <= tx_write;
						if (!clock_phase) begin
							out_bit <= pick(tx_data_holding, bit_order_select);
						end
					end
				end
			end
		end
	end
end

// ********************************************
// dma handshake and done flags
// ********************************************
always @(posedge ref_clk) begin
	if (!rstn) begin
		rx_dma_req <= 1'b0;
		tx_dma_req <= 1'b0;
		rx_req_armed <= 1'b1;
		tx_req_armed <= 1'b1;
		rx_dma_done_flag <= 1'b0;
		tx_dma_done_flag <= 1'b0;
		rx_dma_done_prev <= 1'b0;
		tx_dma_done_prev <= 1'b0;
		dma_irq <= 1'b0;
	end else begin
		rx_dma_done_prev <= rx_dma_done;
		tx_dma_done_prev <= tx_dma_done;
		// both channels advance in the same cycle without arbitration
		if (rx_dma_req && rx_dma_ack) begin
			rx_dma_req <= 1'b0;
			rx_req_armed <= 1'b0;
		end else if (rx_dma_enable && rx_ready && rx_req_armed) begin
			rx_dma_req <= 1'b1;
		end else if (!rx_dma_enable) begin
			rx_dma_req <= 1'b0;
		end
		if (!rx_ready || rx_read) begin
			rx_req_armed <= 1'b1;
		end
		if (tx_dma_req && tx_dma_ack) begin
			tx_dma_req <= 1'b0;
			tx_req_armed <= 1'b0;
		end else if (tx_dma_enable && tx_ready && tx_req_armed) begin
			tx_dma_req <= 1'b1;
		end else if (!tx_dma_enable) begin
			tx_dma_req <= 1'b0;
		end
		if (tx_write) begin
			tx_req_armed <= 1'b1;
		end
		// set beats clear in the same cycle
		if (rx_dma_done && !rx_dma_done_prev) begin
			rx_dma_done_flag <= 1'b1;
		end else if (status_clear) begin
			rx_dma_done_flag <= 1'b0;
		end
		if (tx_dma_done && !tx_dma_done_prev) begin
			tx_dma_done_flag <= 1'b1;
		end else if (status_clear) begin
			tx_dma_done_flag <= 1'b0;
		end
		dma_irq <= (rx_dma_done_flag && rx_dma_irq_enable) || (tx_dma_done_flag && tx_dma_irq_enable);
	end
end

endmodule

// ### design/sptd_map.vh
// constants for the spi transfer engine with dma handshake
// assumes inclusion by the single design file, no other context
`ifndef SPTD_MAP_VH
`define SPTD_MAP_VH

`define SPTD_BAUD_RESET 16'h00ff
`define SPTD_BAUD_MIN 16'h0002
`define SPTD_BITS 4'h8
`define SPTD_SR_RX_DMA_DONE 8
`define SPTD_SR_TX_DMA_DONE 9
`define SPTD_CR_RX_DMA_IE 17
`define SPTD_CR_TX_DMA_IE 18
`define SPTD_DUMMY_BYTE 8'hff

`endif

// ### verif/sptd_properties.sv
// checker for the spi engine: dma handshake, status flags and buffer flags
// assumes a bind onto sptd_core with all inputs in the ref_clk domain
`timescale 1ns/1ps
// ************
// port checker
// ************
module sptd_props (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// buffers
	input wire tx_write,
	input wire tx_ready,
	input wire rx_ready,
	input wire rx_read,
	// dma
	input wire rx_dma_req,
	input wire rx_dma_ack,
	input wire tx_dma_req,
	input wire tx_dma_ack,
	input wire rx_dma_done,
	input wire tx_dma_done,
	// status
	input wire rx_dma_done_flag,
	input wire tx_dma_done_flag,
	input wire status_clear,
	input wire dma_irq,
	input wire rx_dma_irq_enable,
	input wire tx_dma_irq_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_rx_req_drop: assert property (rx_dma_req && rx_dma_ack |-> ##[1:2] !rx_dma_req)
		else $error("rx request held after acknowledge");
	a_tx_req_drop: assert property (tx_dma_req && tx_dma_ack |-> ##[1:2] !tx_dma_req)
		else $error("tx request held after acknowledge");
	a_rx_flag_set: assert property ($rose(rx_dma_done) |-> ##[0:2] rx_dma_done_flag)
		else $error("rx done flag not set");
	a_tx_flag_set: assert property ($rose(tx_dma_done) |-> ##[0:2] tx_dma_done_flag)
		else $error("tx done flag not set");
	a_irq_follows_flag: assert property ((rx_dma_done_flag && rx_dma_irq_enable) || (tx_dma_done_flag &&
		tx_dma_irq_enable) |=> dma_irq)
		else $error("enabled flag without interrupt");
	a_irq_masked: assert property (!(rx_dma_done_flag && rx_dma_irq_enable) && !(tx_dma_done_flag &&
		tx_dma_irq_enable) |=> !dma_irq)
		else $error("interrupt without enabled flag");
	a_flags_clear: assert property (status_clear && !rx_dma_done && !$past(rx_dma_done) && !tx_dma_done &&
		!$past(tx_dma_done) |=> !rx_dma_done_flag && !tx_dma_done_flag)
		else $error("flags survive clear");
	a_rx_ready_hold: assert property (rx_ready && !rx_read |=> rx_ready)
		else $error("received byte lost before read");
	a_tx_write_fill: assert property (tx_write |-> ##2 !tx_ready)
		else $error("holding buffer not filled by write");
endmodule
bind sptd_core sptd_props u_props (.ref_clk, .rstn, .tx_write, .tx_ready, .rx_ready, .rx_read, .rx_dma_req,
	.rx_dma_ack, .tx_dma_req, .tx_dma_ack, .rx_dma_done, .tx_dma_done, .rx_dma_done_flag, .tx_dma_done_flag,
	.status_clear, .dma_irq, .rx_dma_irq_enable, .tx_dma_irq_enable);

// ### verif/sptd_slave_model.sv
// behavioural external spi slave facing the engine in master mode
// assumes the same clock mode and bit order as the engine
`timescale 1ns/1ps
// ***********
// slave model
// ***********
module sptd_slave_model (
	// serial pins
	input wire sclk,
	input wire slave_select_n,
	input wire mosi,
	output reg miso,
	// configuration and data
	input wire clock_polarity,
	input wire clock_phase,
	input wire bit_order_select,
	input wire [7:0] tx_byte,
	output reg [7:0] rx_byte,
	output reg [4:0] pulses,
	output reg first_bit
);
	reg [7:0] sh;
	initial miso = 1'b0;
	always @(negedge slave_select_n) begin
		sh = tx_byte;
		pulses = 5'h00;
		// phase one: selection only inverts miso, with no data bit loaded
		if (!clock_phase) miso = bit_order_select ? sh[7] : sh[0];
		else miso = ~miso;
	end
	// released line shows no stale value
	always @(posedge slave_select_n) miso = ~miso;
	always @(sclk) if (!slave_select_n) begin
		if (sclk != clock_polarity) begin
			pulses = pulses + 5'h01;
			if (clock_phase) miso = bit_order_select ? sh[7] : sh[0];
			else rx_byte = bit_order_select ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
			if (pulses == 5'h01) first_bit = mosi;
		end else begin
			if (clock_phase) rx_byte = bit_order_select ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
			sh = bit_order_select ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
			if (pulses[2:0] == 3'h0) sh = tx_byte;
			if (!clock_phase) miso = bit_order_select ? sh[7] : sh[0];
		end
	end
endmodule

// ### verif/tb_spi_transfer_and_dma_handshake.sv
// self-checking bench: engine as master against a slave model, plus dma handshakes
// assumes the engine's own slave select is held inactive in master mode
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
// *****
// bench
// *****
module tb_spi_transfer_and_dma_handshake;
	reg ref_clk = 0, rstn = 0, enable = 0, master_mode = 1, clock_polarity = 0, clock_phase = 0;
	reg bit_order_select = 1, rx_dma_irq_enable = 0, tx_dma_irq_enable = 0, tx_write = 0, rx_read = 0;
	reg status_clear = 0, rx_dma_enable = 0, tx_dma_enable = 0, rx_dma_ack = 0, tx_dma_ack = 0;
	reg rx_dma_done = 0, tx_dma_done = 0, ss_n = 1, dut_ss_n = 1, bsclk = 0;
	reg [15:0] baud_divisor = 16'h0002;
	reg [7:0] tx_wdata = 8'h00, pt_byte = 8'h00;
	wire [7:0] rx_rdata, m_rx;
	wire [4:0] pulses;
	wire tx_ready, rx_ready, busy, rx_dma_done_flag, tx_dma_done_flag, dma_irq, rx_dma_req, tx_dma_req;
	wire sclk_out, sclk_oe, mosi_out, mosi_oe, miso_in, first_bit, miso_out, miso_oe;
	int errors = 0, check_count = 0, i, n;
	sptd_core u_dut (.ref_clk, .rstn, .enable, .master_mode, .clock_polarity, .clock_phase, .bit_order_select,
		.baud_divisor, .rx_dma_irq_enable, .tx_dma_irq_enable, .tx_write, .tx_wdata, .rx_read, .rx_rdata,
		.tx_ready, .rx_ready, .busy, .status_clear, .rx_dma_done_flag, .tx_dma_done_flag, .dma_irq,
		.rx_dma_enable, .tx_dma_enable, .rx_dma_req, .rx_dma_ack, .tx_dma_req, .tx_dma_ack, .rx_dma_done,
		.tx_dma_done, .sclk_in(master_mode ? sclk_out : bsclk), .sclk_out, .sclk_oe, .slave_select_n(dut_ss_n),
		.mosi_in(miso_out), .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe);
	sptd_slave_model u_slave (.sclk(sclk_out), .slave_select_n(ss_n), .mosi(mosi_out), .miso(miso_in),
		.clock_polarity, .clock_phase, .bit_order_select, .tx_byte(pt_byte), .rx_byte(m_rx), .pulses,
		.first_bit);
	initial forever #2 ref_clk = ~ref_clk;
	task final_report;
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wait_flag(input int sel);
		n = 0;
		do begin @(posedge ref_clk); #1; n++; end
		while (!(sel == 0 ? rx_ready : sel == 1 ? rx_dma_req : tx_dma_req) && n < 400);
		if (n >= 400) errors++;
	endtask
	task write_byte(input [7:0] d);
		@(posedge ref_clk);
		tx_wdata <= d;
		tx_write <= 1;
		@(posedge ref_clk);
		tx_write <= 0;
	endtask
	task read_byte(input [7:0] p, input [7:0] d);
		wait_flag(0);
		@(posedge ref_clk);
		#1;
		`CHK(rx_rdata, p)
		`CHK(m_rx, d)
		@(posedge ref_clk);
		rx_read <= 1;
		@(posedge ref_clk);
		rx_read <= 0;
	endtask
	task xfer(input [7:0] d, input [7:0] p);
		@(posedge ref_clk);
		pt_byte <= p;
		@(posedge ref_clk);
		ss_n <= 0;
		write_byte(d);
		read_byte(p, d);
		`CHK(pulses, 5'h08)
		`CHK(first_bit, bit_order_select ? d[7] : d[0])
		ss_n <= 1;
	endtask
	// loopback through miso_out; the slave is disabled while its byte is loaded
	task slave_byte(input [7:0] d, input [7:0] e);
		@(posedge ref_clk);
		enable <= 0;
		bsclk <= clock_polarity;
		write_byte(d);
		enable <= 1;
		dut_ss_n <= 0;
		repeat (8) begin
			repeat (3) @(posedge ref_clk);
			bsclk <= ~clock_polarity;
			repeat (3) @(posedge ref_clk);
			bsclk <= clock_polarity;
		end
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(rx_rdata, e)
		`CHK(miso_oe, 1'b1)
		dut_ss_n <= 1;
	endtask
	initial begin
		#200000;
		errors++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1;
		enable <= 1;
		for (i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			{bit_order_select, clock_polarity, clock_phase} <= i[2:0];
			repeat (4) @(posedge ref_clk);
			#1;
			`CHK(sclk_out, clock_polarity)
			`CHK(sclk_oe & mosi_oe, 1'b1)
			`CHK(busy, 1'b0)
			xfer(8'h96 ^ {1'b0, i[2:0], 4'h0}, 8'h5a ^ i[7:0]);
		end
		// second byte queued while the first shifts: one idle ref_clk cycle between them
		@(posedge ref_clk);
		pt_byte <= 8'h81;
		@(posedge ref_clk);
		ss_n <= 0;
		write_byte(8'h3c);
		repeat (2) @(posedge ref_clk);
		write_byte(8'hc3);
		read_byte(8'h81, 8'h3c);
		read_byte(8'h81, 8'hc3);
		`CHK(pulses, 5'h10)
		ss_n <= 1;
		rx_dma_enable <= 1;
		tx_dma_enable <= 1;
		rx_dma_irq_enable <= 1;
		wait_flag(2);
		`CHK(tx_dma_req, 1'b1)
		xfer(8'h42, 8'h24);
		`CHK(rx_dma_req & tx_dma_req, 1'b1)
		@(posedge ref_clk);
		rx_dma_ack <= 1;
		tx_dma_ack <= 1;
		@(posedge ref_clk);
		rx_dma_ack <= 0;
		tx_dma_ack <= 0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(rx_dma_req, 1'b0)
		`CHK(tx_dma_req, 1'b0)
		`CHK(tx_ready, 1'b1)
		for (i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			{rx_dma_done, tx_dma_done} <= i ? 2'b01 : 2'b11;
			@(posedge ref_clk);
			{rx_dma_done, tx_dma_done} <= 2'b00;
			repeat (3) @(posedge ref_clk);
			#1;
			`CHK({rx_dma_done_flag, tx_dma_done_flag}, i ? 2'b01 : 2'b11)
			`CHK(dma_irq, i == 1 ? 1'b0 : 1'b1)
			@(posedge ref_clk);
			status_clear <= 1;
			rx_dma_irq_enable <= 0;
			tx_dma_irq_enable <= (i == 1);
			@(posedge ref_clk);
			status_clear <= 0;
			repeat (2) @(posedge ref_clk);
			#1;
			`CHK({rx_dma_done_flag, tx_dma_done_flag}, 2'b00)
		end
		master_mode <= 0;
		slave_byte(8'ha5, 8'hff);
		tx_dma_enable <= 0;
		slave_byte(8'h3c, 8'h3c);
		final_report;
	end
endmodule
